// file: rtl/repeater_rx_detect_config_ctrl.sv
// repeater control: rx-detect, strap decode, signal-detect status, eeprom load
// Summary of operation
// - power up, detect strap 0: manual code 00, input termination high impedance
// - strap R, code 01: probe every 12 ms, stop after 600 ms, then high impedance
// - strap float, code 10: probe every 12 ms until a receiver is found
// - strap 1, code 11: permanent 50 ohm termination in manual mode
// - power-down high: inputs high impedance, all output drivers disabled
// - power-down held high 5 us resets the detect state machine
// - presence override set, then presence value toggled, resets detect machine
// - threshold strap 0, R, F, 1 maps to codes 10, 01, 00, 11
// - per-channel signal-detect status readable at register 0x0A
// - signal detect never gates outputs; only channel power-down and the power-down pin do
// - bus-mode float: act as master, load settings from own eeprom entry
// - eeprom load writes only a fixed subset of register bits
// - after good load revert to slave mode and release the bus
// - a blank eeprom header aborts the load at once; a missing eeprom answer aborts it by time-out
// - each strap decodes to one of four levels selecting pin-mode settings
// - eq levels 1-4 give codes 00-11; pin mode needs spare straps low
// - eq and threshold settings are also reachable through registers
// - bus-mode strap low pin mode, high slave, float master load
// - writes other than to 0x06 are ignored until the register-enable bit 0x06[3] is set
// - master waits for load grant, flags load done, so chains load in turn
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module repeater_rx_detect_config_ctrl
    import rptr_ctrl_pkg::*;
#(
    parameter int PROBE_CYCLES   = PROBE_CYC,
    parameter int SEARCH_CYCLES  = SEARCH_CYC,
    parameter int EE_TIMEOUT     = EE_TIMEOUT_CYC
)
(
    // clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_resetn,
    // straps and power-down
    input  wire logic [STRAP_CNT-1:0][2:0] i_strap_thermo,
    input  wire logic                      i_power_down_in,
    input  wire logic [3:0]                i_dev_addr,
    // analog front end
    input  wire logic                      i_rx_sense,
    input  wire logic [7:0]                i_sd_above,
    output logic                           o_probe,
    output logic [7:0]                     o_term_en,
    output logic [7:0]                     o_drv_en,
    output logic [1:0]                     o_sd_thresh,
    output logic [1:0]                     o_eq_level_group_a,
    output logic [1:0]                     o_eq_level_group_b,
    output logic                           o_eq_valid,
    // register port
    input  wire logic [7:0]                i_addr,
    input  wire logic [7:0]                i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic [7:0]                     o_rdata,
    // eeprom load
    input  wire logic                      i_read_en_n,
    input  wire logic                      i_ee_ack,
    input  wire logic [7:0]                i_ee_data,
    output logic                           o_ee_req,
    output logic [9:0]                     o_ee_addr,
    output logic                           o_bus_owned,
    output logic                           o_all_done_n
);
    typedef struct packed {
        rxd_state_type   rxd;
        logic [1:0]      code;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] win;
        logic [5:0]      pd_cnt;
        logic            probe;
        logic [7:0]      ch_off;
        logic [7:0]      presence;
        logic [7:0]      enable;
        logic [7:0]      ovr;
        logic [7:0]      eq;
        logic [7:0]      sd_stat;
        logic [7:0]      rdata;
        ee_state_type    ee;
        logic [TMR_W-1:0] ee_tmr;
        logic [9:0]      ee_addr;
        logic [1:0]      ee_idx;
        logic            loaded;
    } ctrl_state_type;

    ctrl_state_type st_q;
    ctrl_state_type st_d;
    logic [1:0] lvl [STRAP_CNT];
    logic       pin_mode;
    logic       master_strap;
    logic [1:0] rxd_code;
    logic       pd_reset;
    logic       presence_reset;
    logic       fsm_reset;

    // one decoder per strap
    genvar g;
    generate
        for (g = 0; g < STRAP_CNT; g++)
        begin : g_strap
            strap_level_if lif ();
            assign lif.thermo = i_strap_thermo[g];
            strap_level_dec u_dec (
                .i_clk_sys (i_clk_sys),
                .i_resetn  (i_resetn),
                .lvl       (lif)
            );
            assign lvl[g] = lif.level;
        end
    endgenerate

    // after a good load the part behaves as a slave even with the strap floating
    assign pin_mode     = (lvl[STRAP_BUSMODE] == LVL_0) || (lvl[STRAP_BUSMODE] == LVL_R);
    assign master_strap = (lvl[STRAP_BUSMODE] == LVL_F);

    // overrides count only outside pin mode
    assign rxd_code = (!pin_mode && st_q.ovr[RX_DETECT_OVR_BIT])
                    ? st_q.ovr[RX_DETECT_CODE_LSB +: 2] : lvl[STRAP_RX_DETECT];

    assign pd_reset    = i_power_down_in && (st_q.pd_cnt == 6'(PD_RESET_CYC - 1));
    assign presence_reset = i_wr && (i_addr == REG_PRESENCE) && st_q.enable[REG_EN_BIT]
                          && st_q.presence[PRESENCE_OVR_BIT] && i_wdata[PRESENCE_OVR_BIT]
                          && (i_wdata[PRESENCE_VAL_BIT] != st_q.presence[PRESENCE_VAL_BIT]);
    assign fsm_reset   = pd_reset || presence_reset;

    always_comb
    begin
        st_d       = st_q;
        st_d.probe = 1'b0;
        st_d.rdata = 8'h00;
        st_d.sd_stat = i_sd_above;
        // power-down width counter saturates so one long pulse resets once
        if (!i_power_down_in)
            st_d.pd_cnt = 6'h00;
        else if (st_q.pd_cnt != 6'(PD_RESET_CYC))
            st_d.pd_cnt = st_q.pd_cnt + 6'h01;

        // receiver-detect machine, frozen while powered down except for the reset to idle
        if (fsm_reset)
            st_d.rxd = RXD_IDLE;
        else if (!i_power_down_in)
        begin
            case (st_q.rxd)
                RXD_IDLE:
                begin
                    st_d.code = rxd_code;
                    st_d.tmr  = '0;
                    st_d.win  = '0;
                    if (rxd_code == RXD_MAN_HIZ)
                        st_d.rxd = RXD_HIZ;
                    else if (rxd_code == RXD_MAN_TERM)
                        st_d.rxd = RXD_TERM;
                    else
                        st_d.rxd = RXD_SEARCH;
                end
                RXD_SEARCH:
                begin
                    st_d.tmr = st_q.tmr + TMR_W'(1);
                    st_d.win = st_q.win + TMR_W'(1);
                    if (rxd_code != st_q.code)
                        st_d.rxd = RXD_IDLE;
                    else if (st_q.tmr == TMR_W'(PROBE_CYCLES - 1))
                    begin
                        st_d.tmr   = '0;
                        st_d.probe = 1'b1;
                        if (i_rx_sense)
                            st_d.rxd = RXD_TERM;
                    end
                    else if (st_q.code == RXD_TIMED && st_q.win >= TMR_W'(SEARCH_CYCLES - 1))
                        st_d.rxd = RXD_HIZ;
                end
                RXD_TERM, RXD_HIZ:
                begin
                    if (rxd_code != st_q.code)
                        st_d.rxd = RXD_IDLE;
                end
                default:
                    st_d.rxd = RXD_IDLE;
            endcase
        end

        // register writes; only the enable register is open while locked
        if (i_wr)
        begin
            if (i_addr == REG_ENABLE)
                st_d.enable = i_wdata;
            else if (st_q.enable[REG_EN_BIT])
            begin
                if (i_addr == REG_CH_OFF)
                    st_d.ch_off = i_wdata;
                else if (i_addr == REG_PRESENCE)
                    st_d.presence = i_wdata;
                else if (i_addr == REG_OVERRIDE)
                    st_d.ovr = i_wdata;
                else if (i_addr == REG_EQ)
                    st_d.eq = i_wdata;
            end
        end

        // register reads, data valid for exactly one cycle
        if (i_rd)
        begin
            if (i_addr == REG_CH_OFF)
                st_d.rdata = st_q.ch_off;
            else if (i_addr == REG_PRESENCE)
                st_d.rdata = st_q.presence;
            else if (i_addr == REG_ENABLE)
                st_d.rdata = st_q.enable;
            else if (i_addr == REG_OVERRIDE)
                st_d.rdata = st_q.ovr;
            else if (i_addr == REG_SD_STATUS)
                st_d.rdata = st_q.sd_stat;
            else if (i_addr == REG_EQ)
                st_d.rdata = st_q.eq;
            else
                st_d.rdata = 8'h00;
        end

        // eeprom loader; a load byte bypasses the lock, it is the boot path
        case (st_q.ee)
            EE_IDLE:
            begin
                if (master_strap && !st_q.loaded)
                    st_d.ee = EE_GRANT;
            end
            EE_GRANT:
            begin
                st_d.ee_tmr  = '0;
                st_d.ee_addr = EE_HDR_ADDR;
                if (!master_strap)
                    st_d.ee = EE_IDLE;
                else if (!i_read_en_n)
                    st_d.ee = EE_HDR;
            end
            EE_HDR, EE_DATA:
            begin
                st_d.ee_tmr = st_q.ee_tmr + TMR_W'(1);
                if (i_ee_ack && st_q.ee == EE_HDR)
                begin
                    st_d.ee_tmr = '0;
                    st_d.ee_idx = 2'h0;
                    st_d.ee_addr = EE_BASE_ADDR + 10'(i_dev_addr) * EE_ENTRY_BYTES;
                    // a blank header cannot hold a valid entry
                    st_d.ee = (i_ee_data == EE_BLANK) ? EE_FAIL : EE_DATA;
                end
                else if (i_ee_ack)
                begin
                    st_d.ee_tmr  = '0;
                    st_d.ee_addr = st_q.ee_addr + 10'h001;
                    st_d.ee_idx  = st_q.ee_idx + 2'h1;
                    if (st_q.ee_idx == 2'h0)
                        st_d.ch_off = i_ee_data;
                    else if (st_q.ee_idx == 2'h1)
                        st_d.eq = {4'h0, i_ee_data[3:0]};
                    else
                        st_d.ovr = i_ee_data;
                    if (st_q.ee_idx == EE_LAST_BYTE)
                        st_d.ee = EE_DONE;
                end
                else if (st_q.ee_tmr == TMR_W'(EE_TIMEOUT - 1))
                    st_d.ee = EE_FAIL;
            end
            EE_DONE:
            begin
                st_d.loaded = 1'b1;
                st_d.ee     = EE_IDLE;
            end
            EE_FAIL:
            begin
                if (!master_strap)
                    st_d.ee = EE_IDLE;
            end
            default:
                st_d.ee = EE_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_q         <= '0;
            st_q.rxd     <= RXD_IDLE;
            st_q.ee      <= EE_IDLE;
            st_q.ch_off   <= RST_CH_OFF;
            st_q.presence <= RST_PRESENCE;
            st_q.enable  <= RST_ENABLE;
            st_q.ovr     <= RST_OVERRIDE;
            st_q.eq      <= RST_EQ;
        end
        else
            st_q <= st_d;
    end

    // front-end controls
    assign o_probe     = st_q.probe;
    assign o_term_en   = (!i_power_down_in && st_q.rxd == RXD_TERM)
                       ? ~st_q.ch_off : 8'h00;
    assign o_drv_en    = i_power_down_in ? 8'h00 : ~st_q.ch_off;

    always_comb
    begin
        if (!pin_mode && st_q.ovr[SDTH_OVR_BIT])
            o_sd_thresh = st_q.ovr[SDTH_CODE_LSB +: 2];
        else if (lvl[STRAP_SDTH] == LVL_0)
            o_sd_thresh = SDTH_AT_0;
        else if (lvl[STRAP_SDTH] == LVL_R)
            o_sd_thresh = SDTH_AT_R;
        else if (lvl[STRAP_SDTH] == LVL_F)
            o_sd_thresh = SDTH_AT_F;
        else
            o_sd_thresh = SDTH_AT_1;
    end

    // strap level codes equal the eq field codes
    assign o_eq_level_group_a = pin_mode ? lvl[STRAP_EQ_GRP_A]
                                         : st_q.eq[EQ_GRP_A_LSB +: 2];
    assign o_eq_level_group_b = pin_mode ? lvl[STRAP_EQ_GRP_B]
                                         : st_q.eq[EQ_GRP_B_LSB +: 2];
    assign o_eq_valid = !pin_mode || (lvl[STRAP_SPARE3] == LVL_0
                                      && lvl[STRAP_ADDR2] == LVL_0);

    // register port and eeprom side
    assign o_rdata      = st_q.rdata;
    assign o_ee_req     = (st_q.ee == EE_HDR) || (st_q.ee == EE_DATA);
    assign o_ee_addr    = st_q.ee_addr;
    assign o_bus_owned  = o_ee_req;
    assign o_all_done_n = !st_q.loaded;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    sequence s_grant;
        st_q.ee == EE_GRANT && master_strap && !i_read_en_n;
    endsequence
    sequence s_load_end;
        st_q.ee == EE_DONE ##1 st_q.ee == EE_IDLE;
    endsequence

    a_manual_hiz_term: assert property (st_q.rxd == RXD_HIZ |-> o_term_en == 8'h00)
        else $error("termination on while detect state is high impedance");
    a_probe_spacing: assert property (o_probe |=> !o_probe [*8])
        else $error("probes closer than the interval");
    a_search_found: assert property (st_q.rxd == RXD_SEARCH && st_d.probe && i_rx_sense
        && !fsm_reset && !i_power_down_in && rxd_code == st_q.code |=> st_q.rxd == RXD_TERM)
        else $error("detected receiver did not enable termination");
    a_manual_term: assert property (st_q.rxd == RXD_IDLE && rxd_code == RXD_MAN_TERM
        && !fsm_reset && !i_power_down_in |=> st_q.rxd == RXD_TERM)
        else $error("manual termination mode not entered");
    a_pd_outputs_off: assert property (i_power_down_in |-> o_drv_en == 8'h00
        && o_term_en == 8'h00)
        else $error("outputs active during power down");
    a_pd_fsm_reset: assert property (i_power_down_in && st_q.pd_cnt == 6'(PD_RESET_CYC - 1)
        |=> st_q.rxd == RXD_IDLE)
        else $error("long power down did not reset detect machine");
    a_thresh_map: assert property (pin_mode && lvl[STRAP_SDTH] == LVL_0
        |-> o_sd_thresh == 2'h2)
        else $error("threshold code wrong for level 0");
    a_sd_status_follow: assert property (i_rd && i_addr == REG_SD_STATUS
        |=> o_rdata == $past(st_q.sd_stat))
        else $error("status read does not show signal detect");
    a_drv_not_gated: assert property (!i_power_down_in |-> o_drv_en == ~st_q.ch_off)
        else $error("output driver gated by something other than power down");
    a_load_released: assert property (s_load_end |-> !o_bus_owned && !o_all_done_n)
        else $error("bus kept or done missing after load");
    a_grant_start: assert property (s_grant |=> o_ee_req && o_ee_addr == EE_HDR_ADDR)
        else $error("load did not start on grant");
    a_locked_write: assert property (i_wr && i_addr == REG_CH_OFF && !st_q.enable[REG_EN_BIT]
        && st_q.ee != EE_DATA |=> st_q.ch_off == $past(st_q.ch_off))
        else $error("locked register changed");
    a_fail_idle: assert property (st_q.ee == EE_FAIL |-> !o_bus_owned && o_all_done_n)
        else $error("failed load holds bus or flags done");
endmodule
`default_nettype wire

// file: pkg/rptr_ctrl_pkg.sv
// constants, codes and state encodings shared by the repeater control logic
package rptr_ctrl_pkg;
    // timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int PROBE_MS        = 12;
    localparam int SEARCH_MS       = 600;
    localparam int PD_RESET_NS     = 5000;
    localparam int EE_TIMEOUT_US   = 1000;
    localparam int PROBE_CYC       = PROBE_MS * (CLK_HZ / 1000);
    localparam int SEARCH_CYC      = SEARCH_MS * (CLK_HZ / 1000);
    localparam int PD_RESET_CYC    = (PD_RESET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int EE_TIMEOUT_CYC  = EE_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int TMR_W           = 23;
    // four-level strap codes
    localparam logic [1:0] LVL_0   = 2'h0;
    localparam logic [1:0] LVL_R   = 2'h1;
    localparam logic [1:0] LVL_F   = 2'h2;
    localparam logic [1:0] LVL_1   = 2'h3;
    // strap index in the strap array
    localparam int STRAP_RX_DETECT = 0;
    localparam int STRAP_SDTH      = 1;
    localparam int STRAP_BUSMODE   = 2;
    localparam int STRAP_EQ_GRP_A  = 3;
    localparam int STRAP_EQ_GRP_B  = 4;
    localparam int STRAP_SPARE3    = 5;
    localparam int STRAP_ADDR2     = 6;
    localparam int STRAP_CNT       = 7;
    // receiver-detect mode codes
    localparam logic [1:0] RXD_MAN_HIZ  = 2'h0;
    localparam logic [1:0] RXD_TIMED    = 2'h1;
    localparam logic [1:0] RXD_ENDLESS  = 2'h2;
    localparam logic [1:0] RXD_MAN_TERM = 2'h3;
    // threshold codes per strap level
    localparam logic [1:0] SDTH_AT_0 = 2'h2;
    localparam logic [1:0] SDTH_AT_R = 2'h1;
    localparam logic [1:0] SDTH_AT_F = 2'h0;
    localparam logic [1:0] SDTH_AT_1 = 2'h3;
    // register offsets
    localparam logic [7:0] REG_CH_OFF    = 8'h01;
    localparam logic [7:0] REG_PRESENCE  = 8'h02;
    localparam logic [7:0] REG_ENABLE    = 8'h06;
    localparam logic [7:0] REG_OVERRIDE  = 8'h08;
    localparam logic [7:0] REG_SD_STATUS = 8'h0A;
    localparam logic [7:0] REG_EQ        = 8'h0C;
    // field positions
    localparam int PRESENCE_OVR_BIT   = 7;
    localparam int PRESENCE_VAL_BIT   = 6;
    localparam int REG_EN_BIT         = 3;
    localparam int SDTH_OVR_BIT       = 7;
    localparam int RX_DETECT_OVR_BIT  = 6;
    localparam int RX_DETECT_CODE_LSB = 4;
    localparam int SDTH_CODE_LSB      = 0;
    localparam int EQ_GRP_A_LSB       = 0;
    localparam int EQ_GRP_B_LSB       = 2;
    // reset values
    localparam logic [7:0] RST_CH_OFF   = 8'h00;
    localparam logic [7:0] RST_PRESENCE = 8'h00;
    localparam logic [7:0] RST_ENABLE   = 8'h00;
    localparam logic [7:0] RST_OVERRIDE = 8'h00;
    localparam logic [7:0] RST_EQ       = 8'h00;
    // eeprom layout
    localparam logic [9:0] EE_HDR_ADDR    = 10'h000;
    localparam logic [9:0] EE_BASE_ADDR   = 10'h003;
    localparam logic [9:0] EE_ENTRY_BYTES = 10'h025;
    localparam logic [7:0] EE_BLANK       = 8'hFF;
    localparam logic [1:0] EE_LAST_BYTE   = 2'h2;
    // state encodings
    typedef enum logic [3:0] {
        RXD_IDLE   = 4'b0001,
        RXD_SEARCH = 4'b0010,
        RXD_TERM   = 4'b0100,
        RXD_HIZ    = 4'b1000
    } rxd_state_type;
    typedef enum logic [5:0] {
        EE_IDLE  = 6'b000001,
        EE_GRANT = 6'b000010,
        EE_HDR   = 6'b000100,
        EE_DATA  = 6'b001000,
        EE_DONE  = 6'b010000,
        EE_FAIL  = 6'b100000
    } ee_state_type;
endpackage

// file: pkg/strap_level_if.sv
// carrier between a strap comparator group and its level decoder
`timescale 1ns/100ps
`default_nettype none
interface strap_level_if;
    logic [2:0] thermo;
    logic [1:0] level;
    modport dec  (input thermo, output level);
    modport user (output thermo, input level);
endinterface
`default_nettype wire

// file: rtl/strap_level_dec.sv
// four-level strap decoder: comparator thermometer code to level code
`timescale 1ns/100ps
`default_nettype none
module strap_level_dec
    import rptr_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic      i_clk_sys,
    input  wire logic      i_resetn,
    // strap
    strap_level_if.dec     lvl
);
    typedef struct packed {
        logic [1:0] level;
    } dec_state_type;

    dec_state_type st_q;
    dec_state_type st_d;

    always_comb
    begin
        st_d = st_q;
        if (lvl.thermo[2])
            st_d.level = LVL_1;
        else if (lvl.thermo[1])
            st_d.level = LVL_F;
        else if (lvl.thermo[0])
            st_d.level = LVL_R;
        else
            st_d.level = LVL_0;
    end

    // reset to float, the level an open pin settles at
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            st_q <= '{level: LVL_F};
        else
            st_q <= st_d;
    end

    assign lvl.level = st_q.level;
endmodule
`default_nettype wire

// file: tb/cfg_eeprom_model.sv
// behavioural configuration eeprom answering byte requests after a delay
`timescale 1ns/100ps
`default_nettype none
module cfg_eeprom_model
#(
    parameter int DELAY = 3
)
(
    // clock
    input  wire logic       i_clk_sys,
    // byte request side
    input  wire logic       i_req,
    input  wire logic [9:0] i_addr,
    input  wire logic       i_blank,
    input  wire logic       i_mute,
    output logic            o_ack,
    output logic [7:0]      o_data
);
    logic [7:0] mem [0:1023];
    logic       ack_q  = 1'h0;
    logic [7:0] data_q = 8'h00;
    int         wait_q = 0;
    initial
    begin
        mem[0]  = 8'h01;
        // device 0 entry is a decoy: the bench straps device 1, entry at 3 + 37
        mem[3]  = 8'h81;
        mem[40] = 8'h3C;
        mem[41] = 8'h06;
        mem[42] = 8'h00;
    end
    assign o_ack  = ack_q;
    assign o_data = data_q;
    // data lines toggle when not answering, so a stale byte is never taken
    always @(posedge i_clk_sys)
    begin
        ack_q  <= 1'h0;
        data_q <= ~data_q;
        if (i_req && !ack_q && !i_mute)
        begin
            wait_q <= wait_q + 1;
            if (wait_q == DELAY)
            begin
                ack_q  <= 1'h1;
                data_q <= i_blank ? 8'hFF : mem[i_addr];
                wait_q <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/repeater_rx_detect_config_ctrl_tb.sv
// self-checking bench for the repeater control block
`timescale 1ns/100ps
`default_nettype none
module repeater_rx_detect_config_ctrl_tb;
    import rptr_ctrl_pkg::*;
    logic clk = 0, rstn = 0, pd = 0, rxs = 0, wr = 0, rd = 0, ren_n = 1, blank = 0, mute = 0;
    logic [3:0] dadr = 4'h1;
    logic probe, eqv, ack, req, own, done_n;
    logic [STRAP_CNT-1:0][2:0] st = '0;
    logic [7:0] sd = 0, a = 0, wd = 0, rdat, term, drv, edat;
    logic [1:0] sdth, eq_level_group_a, eq_level_group_b;
    logic [9:0] eaddr;
    logic [1:0] tht [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    int   n_fail = 0, checks = 0, k;
    always #50 clk = ~clk;
    repeater_rx_detect_config_ctrl #(.PROBE_CYCLES(20), .SEARCH_CYCLES(200), .EE_TIMEOUT(30)) uut
    (.i_clk_sys(clk), .i_resetn(rstn), .i_strap_thermo(st), .i_power_down_in(pd),
     .i_dev_addr(dadr), .i_rx_sense(rxs), .i_sd_above(sd), .o_probe(probe), .o_term_en(term),
     .o_drv_en(drv), .o_sd_thresh(sdth), .o_eq_level_group_a(eq_level_group_a), .o_eq_level_group_b(eq_level_group_b),
     .o_eq_valid(eqv), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
     .i_read_en_n(ren_n), .i_ee_ack(ack), .i_ee_data(edat), .o_ee_req(req),
     .o_ee_addr(eaddr), .o_bus_owned(own), .o_all_done_n(done_n));
    cfg_eeprom_model eeprom
    (.i_clk_sys(clk), .i_req(req), .i_addr(eaddr), .i_blank(blank), .i_mute(mute),
     .o_ack(ack), .o_data(edat));
    task end_sim;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task ss(input int i, input int l);
        st[i] <= {1'(l == 3), 1'(l >= 2), 1'(l >= 1)};
    endtask
    task cnt(input int n);
        k = 0;
        repeat (n) begin @(posedge clk); #1; k += (probe !== 1'b0) ? 1 : 0; end
    endtask
    task rst;
        @(posedge clk) rstn <= 1'h0;
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        cyc(2);
    endtask
    task wrr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        a  <= ad;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task rc(input logic [7:0] ad, input logic [7:0] ex);
        @(posedge clk);
        a  <= ad;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk("rdata", ex, rdat);
    endtask
    initial
    begin
        #2_000_000 n_fail++;
        end_sim();
    end
    initial
    begin
        rst();
        chk("done_n", 8'h01, 8'(done_n));
        chk("term", 8'h00, term);
        for (int l = 0; l < 4; l++)
        begin
            @(posedge clk);
            ss(STRAP_SDTH, l);
            ss(STRAP_EQ_GRP_A, l);
            ss(STRAP_EQ_GRP_B, 3 - l);
            cyc(3);
            chk("sd_thresh", 8'(tht[l]), 8'(sdth));
            chk("eq_a", 8'(l), 8'(eq_level_group_a));
            chk("eq_b", 8'(3 - l), 8'(eq_level_group_b));
            chk("eq_valid", 8'h01, 8'(eqv));
        end
        @(posedge clk) ss(STRAP_SPARE3, 3);
        cyc(3);
        chk("eq_valid", 8'h00, 8'(eqv));
        @(posedge clk) ss(STRAP_SPARE3, 0);
        $display("test straps done");
        @(posedge clk) ss(STRAP_RX_DETECT, 3);
        cyc(3);
        chk("term", 8'hFF, term);
        @(posedge clk) pd <= 1'h1;
        cyc(2);
        chk("term", 8'h00, term);
        chk("drv", 8'h00, drv);
        @(posedge clk) ss(STRAP_RX_DETECT, 1);
        cyc(60);
        @(posedge clk) pd <= 1'h0;
        cnt(300);
        chk("probes", 8'h01, 8'(k >= 9 && k <= 10));
        cnt(100);
        chk("probes", 8'h00, 8'(k));
        chk("term", 8'h00, term);
        @(posedge clk) pd <= 1'h1;
        rxs <= 1'h1;
        cyc(60);
        @(posedge clk) pd <= 1'h0;
        cyc(60);
        chk("term", 8'hFF, term);
        @(posedge clk) pd <= 1'h1;
        rxs <= 1'h0;
        ss(STRAP_RX_DETECT, 2);
        cyc(60);
        @(posedge clk) pd <= 1'h0;
        cnt(400);
        chk("probes", 8'h01, 8'(k >= 19));
        @(posedge clk) rxs <= 1'h1;
        cyc(25);
        chk("term", 8'hFF, term);
        $display("test detect done");
        @(posedge clk) ss(STRAP_BUSMODE, 3);
        rxs <= 1'h0;
        sd  <= 8'hA5;
        wrr(8'h01, 8'hFF);
        rc(8'h01, 8'h00);
        wrr(8'h06, 8'h08);
        wrr(8'h01, 8'h0F);
        rc(8'h01, 8'h0F);
        chk("drv", 8'hF0, drv);
        rc(8'h0A, 8'hA5);
        rc(8'h03, 8'h00);
        wrr(8'h0C, 8'h09);
        cyc(1);
        chk("eq_a", 8'h01, 8'(eq_level_group_a));
        chk("eq_b", 8'h02, 8'(eq_level_group_b));
        wrr(8'h08, 8'h60);
        wrr(8'h02, 8'h80);
        wrr(8'h02, 8'hC0);
        cyc(3);
        chk("term", 8'h00, term);
        $display("test registers done");
        @(posedge clk) ss(STRAP_BUSMODE, 2);
        rst();
        cyc(20);
        chk("ee_req", 8'h00, 8'(req));
        @(posedge clk) ren_n <= 1'h0;
        for (int i = 0; i < 300 && done_n !== 1'h0; i++) cyc(1);
        chk("done_n", 8'h00, 8'(done_n));
        if (done_n !== 1'h0) end_sim();
        chk("bus_owned", 8'h00, 8'(own));
        chk("drv", 8'hC3, drv);
        rc(8'h0C, 8'h06);
        rc(8'h02, 8'h00);
        @(posedge clk) blank <= 1'h1;
        rst();
        cyc(200);
        chk("done_n", 8'h01, 8'(done_n));
        chk("bus_owned", 8'h00, 8'(own));
        @(posedge clk) blank <= 1'h0;
        mute <= 1'h1;
        rst();
        cyc(10);
        chk("bus_owned", 8'h01, 8'(own));
        cyc(40);
        chk("bus_owned", 8'h00, 8'(own));
        chk("done_n", 8'h01, 8'(done_n));
        $display("test eeprom done");
        end_sim();
    end
endmodule
`default_nettype wire
